// ---- hdl/reply_status_encoder.sv ----
// What this block does
// - Two status bytes go out ahead of every reply payload.
// - Any comm fault sets first-byte bit 7, other bits name the fault.
// - Second byte is all zeros when a comm fault is reported.
// - No fault: bit 7 clear, command-response value in bits 6 to 0.
// - Fault bits flag parity, overrun and framing errors of received characters.
// - Fault bits also flag receive buffer overflow and checksum mismatch.
// - Response is an integer; 7 write-protect, 16 restricted, 32 busy, 64 unimplemented.
// - Response 0 no error, 1 undefined, 2 to 5 selection/size/short errors.
// - Response 6 is a rarely used device-specific error.
// - Responses 8 to 15 and 28 mean different things per command.
// - Second byte bits 7 to 4: malfunction, config changed, cold start, more status.
// - Second byte bit 3 output fixed, bit 2 output saturated.
// - Second byte bit 1 non-primary out of limits, bit 0 primary out of limits.
// - Condition flags combine freely as a bitwise OR.
// - Characters are start, eight data, odd parity, stop; parity is checked.
`timescale 1ns/1ps
`default_nettype none

module reply_status_encoder (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Received characters from the serial receiver
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char_data,
	input  wire logic        rx_char_parity,
	input  wire logic        rx_char_stop,
	input  wire logic        rx_overrun,
	input  wire logic        rx_buf_overflow,
	input  wire logic        rx_checksum_err,
	// Device condition events from measurement and output logic
	input  wire logic [7:0]  cond_evt,
	// Reply transmitter handshake
	input  wire logic        reply_start,
	input  wire logic        tx_ready,
	output var  logic [7:0]  tx_byte,
	output var  logic        tx_valid,
	output var  logic        status_done,
	output var  logic        busy
);

	reply_status_pkg::tx_state_e state_r;
	reply_status_pkg::tx_state_e state_nxt;

	logic [6:0]  resp_code_r;
	logic [7:0]  byte1_r;
	logic [7:0]  byte2_r;
	logic [15:0] reply_cnt_r;
	logic [6:0]  fault_q;
	logic [7:0]  cond_q;
	logic [6:0]  fault_set;
	logic [7:0]  cond_set;
	logic [7:0]  cond_sw_set;
	logic        compose;
	logic        parity_bad;
	logic        framing_bad;
	logic        any_fault;
	logic [7:0]  byte1_nxt;
	logic [7:0]  byte2_nxt;
	logic        apb_access;
	logic        apb_wr;
	logic        addr_ok;

	// Odd parity: data plus parity bit must hold an odd count of ones
	assign parity_bad  = rx_char_valid & ~(^{rx_char_data, rx_char_parity});
	assign framing_bad = rx_char_valid & ~rx_char_stop;

	// Fault events mapped to their first-byte positions
	always_comb begin
		fault_set = 7'h00;
		fault_set[reply_status_pkg::FB_PARITY]   = parity_bad;
		fault_set[reply_status_pkg::FB_OVERRUN]  = rx_overrun;
		fault_set[reply_status_pkg::FB_FRAMING]  = framing_bad;
		fault_set[reply_status_pkg::FB_CHECKSUM] = rx_checksum_err;
		fault_set[reply_status_pkg::FB_RX_OVFL]  = rx_buf_overflow;
	end

	// Reply composition takes a snapshot and clears the latches in one step
	assign compose = (state_r == reply_status_pkg::ST_IDLE) & reply_start;

	sticky_flags #(
		.W(7)
	) u_fault_flags (
		.clk  (clk),
		.rst_n(rst_n),
		.set  (fault_set),
		.clear(compose),
		.q    (fault_q)
	);

	// Conditions come from hardware events or from firmware writes
	assign cond_set = cond_evt | cond_sw_set;

	sticky_flags #(
		.W(8)
	) u_cond_flags (
		.clk  (clk),
		.rst_n(rst_n),
		.set  (cond_set),
		.clear(compose),
		.q    (cond_q)
	);

	// Reserved and unused fault bits never reach the wire
	assign any_fault = |fault_q;

	always_comb begin
		byte1_nxt = 8'h00;
		byte2_nxt = 8'h00;
		if (any_fault) begin
			byte1_nxt = {1'b1, fault_q};
			byte1_nxt[reply_status_pkg::FB_RESERVED] = 1'b0;
			byte1_nxt[reply_status_pkg::FB_UNUSED0]  = 1'b0;
			byte2_nxt = 8'h00;
		end else begin
			// Code passes as an integer, any 7-bit value is legal
			byte1_nxt = {1'b0, resp_code_r};
			byte2_nxt = cond_q;
		end
	end

	// Sender next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			reply_status_pkg::ST_IDLE: begin
				if (reply_start) begin
					state_nxt = reply_status_pkg::ST_BYTE1;
				end
			end
			reply_status_pkg::ST_BYTE1: begin
				if (tx_ready) begin
					state_nxt = reply_status_pkg::ST_BYTE2;
				end
			end
			reply_status_pkg::ST_BYTE2: begin
				if (tx_ready) begin
					state_nxt = reply_status_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = reply_status_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= reply_status_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Snapshot of both status bytes, held for the whole reply
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte1_r <= 8'h00;
			byte2_r <= 8'h00;
		end else if (compose) begin
			byte1_r <= byte1_nxt;
			byte2_r <= byte2_nxt;
		end
	end

	// Byte stream: first status byte, second status byte, then payload may follow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_byte     <= 8'h00;
			tx_valid    <= 1'b0;
			status_done <= 1'b0;
		end else begin
			status_done <= 1'b0;
			case (state_r)
				reply_status_pkg::ST_IDLE: begin
					if (reply_start) begin
						tx_byte  <= byte1_nxt;
						tx_valid <= 1'b1;
					end
				end
				reply_status_pkg::ST_BYTE1: begin
					if (tx_ready) begin
						tx_byte <= byte2_r;
					end
				end
				reply_status_pkg::ST_BYTE2: begin
					if (tx_ready) begin
						tx_valid    <= 1'b0;
						tx_byte     <= 8'h00;
						status_done <= 1'b1;
					end
				end
				default: begin
					tx_valid <= 1'b0;
				end
			endcase
		end
	end

	// Busy mirrors the sender so firmware knows a reply is in flight
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= (state_nxt != reply_status_pkg::ST_IDLE);
		end
	end

	// Count of replies composed, wraps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_cnt_r <= reply_status_pkg::CNT_RST;
		end else if (compose) begin
			reply_cnt_r <= reply_cnt_r + 16'h0001;
		end
	end

	// APB decode; one wait state keeps pready and prdata registered
	assign apb_access = psel & penable & ~pready;
	assign apb_wr     = apb_access & pwrite;
	assign addr_ok    = (paddr == reply_status_pkg::OFS_RESP_CODE)
		| (paddr == reply_status_pkg::OFS_COND_SET)
		| (paddr == reply_status_pkg::OFS_PENDING)
		| (paddr == reply_status_pkg::OFS_LAST_REPLY)
		| (paddr == reply_status_pkg::OFS_REPLY_CNT);

	// Response code written by firmware before each reply
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_code_r <= reply_status_pkg::RESP_CODE_RST;
		end else if (apb_wr && pstrb[0] && paddr == reply_status_pkg::OFS_RESP_CODE) begin
			resp_code_r <= pwdata[6:0];
		end
	end

	// Write-one-to-set pulse for condition flags
	always_comb begin
		cond_sw_set = reply_status_pkg::COND_RST;
		if (apb_wr && pstrb[0] && paddr == reply_status_pkg::OFS_COND_SET) begin
			cond_sw_set = pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access & ~addr_ok;
			prdata  <= 32'h0000_0000;
			if (apb_access && !pwrite) begin
				case (paddr)
					reply_status_pkg::OFS_RESP_CODE: begin
						prdata <= {25'h000_0000, resp_code_r};
					end
					reply_status_pkg::OFS_PENDING: begin
						prdata <= {16'h0000, cond_q, 1'b0, fault_q};
					end
					reply_status_pkg::OFS_LAST_REPLY: begin
						prdata <= {16'h0000, byte2_r, byte1_r};
					end
					reply_status_pkg::OFS_REPLY_CNT: begin
						prdata <= {16'h0000, reply_cnt_r};
					end
					default: begin
						prdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Checks on the composed bytes and the sequence

	a_fault_top_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(compose && any_fault) |=> (tx_byte[7] && tx_valid))
		else $error("fault not flagged in first status byte");

	a_fault_zero_second: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == reply_status_pkg::ST_BYTE1 && tx_ready && byte1_r[7])
		|=> (tx_byte == 8'h00 && state_r == reply_status_pkg::ST_BYTE2))
		else $error("second byte not zero after fault");

	a_resp_code_pass: assert property (@(posedge clk) disable iff (!rst_n)
		(compose && !any_fault) |=> (tx_byte == {1'b0, $past(resp_code_r)}))
		else $error("first byte does not carry response code");

	a_parity_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(rx_char_valid && !(^{rx_char_data, rx_char_parity}))
		|=> fault_q[reply_status_pkg::FB_PARITY])
		else $error("parity fault not latched");

	a_framing_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(rx_char_valid && !rx_char_stop) |=> fault_q[reply_status_pkg::FB_FRAMING])
		else $error("framing fault not latched");

	a_checksum_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(rx_checksum_err || rx_buf_overflow)
		|=> (fault_q[reply_status_pkg::FB_CHECKSUM] || fault_q[reply_status_pkg::FB_RX_OVFL]))
		else $error("checksum or overflow fault not latched");

	a_cond_flags_sent: assert property (@(posedge clk) disable iff (!rst_n)
		(compose && !any_fault) |=> (byte2_r == $past(cond_q)))
		else $error("condition flags not captured");

	a_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
		##1 ((cond_q & $past(cond_set)) == $past(cond_set)))
		else $error("condition event lost");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(tx_valid && state_r == reply_status_pkg::ST_BYTE1 && tx_byte[7])
		|-> (tx_byte[reply_status_pkg::FB_RESERVED] == 1'b0))
		else $error("reserved fault bit sent as one");

	a_two_bytes_done: assert property (@(posedge clk) disable iff (!rst_n)
		compose |=> (tx_valid && !status_done) [*1] ##1 (tx_valid || status_done))
		else $error("status bytes not sent before done");

	a_done_after_byte2: assert property (@(posedge clk) disable iff (!rst_n)
		status_done |-> $past(state_r == reply_status_pkg::ST_BYTE2 && tx_ready))
		else $error("done without second status byte");

endmodule

`default_nettype wire

// ---- hdl/sticky_flags.sv ----
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic         clear,
	output var  logic [W-1:0] q
);

	// Set beats clear so an event in the snapshot cycle waits for the next reply
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= (clear ? '0 : q) | set;
		end
	end

endmodule

`default_nettype wire

// ---- shared/reply_status_pkg.sv ----
package reply_status_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_RESP_CODE  = 8'h00;
	localparam logic [7:0] OFS_COND_SET   = 8'h04;
	localparam logic [7:0] OFS_PENDING    = 8'h08;
	localparam logic [7:0] OFS_LAST_REPLY = 8'h0C;
	localparam logic [7:0] OFS_REPLY_CNT  = 8'h10;

	// Reset values
	localparam logic [6:0]  RESP_CODE_RST = 7'h00;
	localparam logic [7:0]  COND_RST      = 8'h00;
	localparam logic [15:0] CNT_RST       = 16'h0000;

	// First byte: communication fault field positions
	localparam int unsigned FB_COMM_FAULT = 7;
	localparam int unsigned FB_PARITY     = 6;
	localparam int unsigned FB_OVERRUN    = 5;
	localparam int unsigned FB_FRAMING    = 4;
	localparam int unsigned FB_CHECKSUM   = 3;
	localparam int unsigned FB_RESERVED   = 2;
	localparam int unsigned FB_RX_OVFL    = 1;
	localparam int unsigned FB_UNUSED0    = 0;

	// Second byte: device condition flag positions
	localparam int unsigned SB_MALFUNCTION = 7;
	localparam int unsigned SB_CFG_CHANGED = 6;
	localparam int unsigned SB_COLD_START  = 5;
	localparam int unsigned SB_MORE_STATUS = 4;
	localparam int unsigned SB_AO_FIXED    = 3;
	localparam int unsigned SB_AO_SATURATE = 2;
	localparam int unsigned SB_NONPV_LIMIT = 1;
	localparam int unsigned SB_PV_LIMIT    = 0;

	// Command-response integer codes
	localparam logic [6:0] RC_NO_ERROR      = 7'h00;
	localparam logic [6:0] RC_INVALID_SEL   = 7'h02;
	localparam logic [6:0] RC_PARAM_HIGH    = 7'h03;
	localparam logic [6:0] RC_PARAM_LOW     = 7'h04;
	localparam logic [6:0] RC_TOO_FEW_BYTES = 7'h05;
	localparam logic [6:0] RC_DEV_SPECIFIC  = 7'h06;
	localparam logic [6:0] RC_WRITE_PROTECT = 7'h07;
	localparam logic [6:0] RC_ACCESS_RESTR  = 7'h10;
	localparam logic [6:0] RC_MULTI_28      = 7'h1C;
	localparam logic [6:0] RC_BUSY          = 7'h20;
	localparam logic [6:0] RC_NOT_IMPL      = 7'h40;

	// Reply-status sender states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BYTE1 = 2'b01,
		ST_BYTE2 = 2'b10
	} tx_state_e;

endpackage

// ---- test/reply_sink.sv ----
`timescale 1ns/1ps
`default_nettype none

module reply_sink (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	input  wire logic       stall,
	output var  logic       tx_ready
);
	logic [7:0] got[$];

	// Line side; a stall holds the byte where it stands
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !stall;
			if (tx_valid && tx_ready) got.push_back(tx_byte);
		end
	end
endmodule

`default_nettype wire

// ---- test/reply_status_encoder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module reply_status_encoder_tb_top;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, rxd, cev, tx_byte, lb1, lb2;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        rxv, rxp, rxs, rxo, rxf, rxc, rstart, tx_ready, tx_valid;
	logic        sdone, busy, stall;
	integer      err_count, samples_checked, seed, flt, cnd, nrep, i;
	int          codes[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15, 16, 28, 32, 64, 127};

	reply_status_encoder i_reply_status_encoder (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_char_valid(rxv), .rx_char_data(rxd), .rx_char_parity(rxp),
		.rx_char_stop(rxs), .rx_overrun(rxo), .rx_buf_overflow(rxf),
		.rx_checksum_err(rxc), .cond_evt(cev), .reply_start(rstart),
		.tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.status_done(sdone), .busy(busy)
	);

	reply_sink i_reply_sink (
		.clk(clk), .rst_n(rst_n), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.stall(stall), .tx_ready(tx_ready)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Random line stalls
	always @(posedge clk) stall <= 1'($random(seed));

	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			samples_checked++;
			if (g !== e) begin
				err_count++;
				$display("mismatch %s exp %h got %h", nm, e, g);
			end
		end
	endtask

	task automatic chk_tx(input string nm, input logic [7:0] e, input logic [7:0] g);
		chk_reg(nm, {24'h0, e}, {24'h0, g});
	endtask

	// Request held until pready is seen at a rising edge; only the watchdog ends the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			psel    <= 1'b1;
			penable <= 1'b0;
			pwrite  <= w;
			paddr   <= a;
			pwdata  <= d;
			@(posedge clk);
			penable <= 1'b1;
			do begin
				@(posedge clk);
			end while (pready !== 1'b1);
			// Values read here are those that stood at this edge
			rd = prdata;
			er = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// f: parity, framing, overrun, checksum, overflow
	task automatic ev(input logic [4:0] f, input logic [7:0] c);
		logic [7:0] d;
		begin
			d = 8'($random(seed));
			@(posedge clk);
			rxv <= 1'b1;
			rxd <= d;
			rxp <= ~^d ^ f[0];
			rxs <= ~f[1];
			rxo <= f[2];
			rxc <= f[3];
			rxf <= f[4];
			cev <= c;
			@(posedge clk);
			{rxv, rxo, rxc, rxf, cev} <= '0;
			flt |= (f[0] << 6) | (f[2] << 5) | (f[1] << 4) | (f[3] << 3) | (f[4] << 1);
			cnd |= c;
		end
	endtask

	// One reply; expected bytes come from the model
	task automatic rep(input logic [6:0] rc);
		begin
			apb(1'b1, reply_status_pkg::OFS_RESP_CODE, {25'h0, rc});
			lb1 = (flt != 0) ? (8'h80 | flt[7:0]) : {1'b0, rc};
			lb2 = (flt != 0) ? 8'h00 : cnd[7:0];
			@(posedge clk);
			rstart <= 1'b1;
			// Held over a second edge, which falls while busy and must be refused
			repeat (2) @(posedge clk);
			rstart <= 1'b0;
			@(negedge clk);
			chk_tx("busy on", 8'h1, {7'h0, busy});
			chk_tx("valid on", 8'h1, {7'h0, tx_valid});
			while (sdone !== 1'b1) @(negedge clk);
			chk_tx("count", 8'd2, 8'(i_reply_sink.got.size()));
			chk_tx("byte1", lb1, i_reply_sink.got[0]);
			chk_tx("byte2", lb2, i_reply_sink.got[1]);
			chk_tx("busy", 8'h0, {7'h0, busy});
			i_reply_sink.got.delete();
			flt = 0;
			cnd = 0;
			nrep++;
		end
	endtask

	task automatic tally_and_finish;
		begin
			$display("checked %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0) begin
				$display("Run complete: PASS");
			end else begin
				$display("Run complete: FAIL");
			end
			$finish;
		end
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{rxv, rxd, rxp, rxs, rxo, rxf, rxc, cev, rstart} = '0;
		pstrb = 4'hf;
		seed = 32'h9ec2;
		{err_count, samples_checked, flt, cnd, nrep} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, reply_status_pkg::OFS_RESP_CODE, 32'h0);
		chk_reg("resp reset", 32'h0, rd);
		// Codes with stacked condition events
		foreach (codes[i]) begin
			ev(5'h00, 8'($random(seed)));
			ev(5'h00, 8'($random(seed)));
			rep(codes[i][6:0]);
		end
		// Each fault alone, then all together
		for (i = 0; i < 5; i++) begin
			ev(5'h01 << i, 8'hff);
			rep(7'h05);
		end
		ev(5'h1f, 8'h3c);
		rep(7'h07);
		// Register view of pending and last reply
		apb(1'b1, reply_status_pkg::OFS_COND_SET, 32'h0000_00a5);
		cnd |= 8'ha5;
		ev(5'h04, 8'h00);
		apb(1'b0, reply_status_pkg::OFS_PENDING, 32'h0);
		chk_reg("pending", {16'h0, cnd[7:0], 1'b0, flt[6:0]}, rd);
		apb(1'b0, reply_status_pkg::OFS_COND_SET, 32'h0);
		chk_reg("cond_set rd", 32'h0, rd);
		rep(7'h20);
		apb(1'b0, reply_status_pkg::OFS_LAST_REPLY, 32'h0);
		chk_reg("last reply", {16'h0, lb2, lb1}, rd);
		apb(1'b0, reply_status_pkg::OFS_REPLY_CNT, 32'h0);
		chk_reg("reply count", nrep, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk_reg("unmapped", 32'h1, {31'h0, er});
		chk_reg("unmapped rd", 32'h0, rd);
		tally_and_finish;
	end
endmodule

`default_nettype wire
